// file: core/msie_pkg.sv
// Package with the constants and types of the move, shift and indirect load unit.
package msie_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int MSIE_DATA_W = 8;
    localparam int MSIE_PTR_W  = 12;
    localparam int MSIE_FILE_W = 7;
    localparam int MSIE_OFS_W  = 6;
    localparam int MSIE_MEM_DEPTH = 4096;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses on the APB)
    // ------------------------------------------------------------------
    localparam logic [7:0] MSIE_OFS_CMD    = 8'h00;
    localparam logic [7:0] MSIE_OFS_WREG   = 8'h04;
    localparam logic [7:0] MSIE_OFS_STATUS = 8'h08;
    localparam logic [7:0] MSIE_OFS_PTR0   = 8'h0C;
    localparam logic [7:0] MSIE_OFS_PTR1   = 8'h10;
    localparam logic [7:0] MSIE_OFS_MADDR  = 8'h14;
    localparam logic [7:0] MSIE_OFS_MDATA  = 8'h18;

    // ------------------------------------------------------------------
    // Command word fields
    // ------------------------------------------------------------------
    localparam int MSIE_CMD_OP_LSB  = 0;
    localparam int MSIE_CMD_DEST    = 2;
    localparam int MSIE_CMD_PSEL    = 3;
    localparam int MSIE_CMD_REL     = 4;
    localparam int MSIE_CMD_PMODE_LSB = 5;
    localparam int MSIE_CMD_F_LSB   = 8;
    localparam int MSIE_CMD_K_LSB   = 16;

    // Status register fields.
    localparam int MSIE_ST_CARRY = 0;
    localparam int MSIE_ST_ZERO  = 1;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0]  MSIE_RST_W   = 8'h00;
    localparam logic [11:0] MSIE_RST_PTR = 12'h000;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MSIE_OP_NONE  = 2'b00,
        MSIE_OP_MOVE  = 2'b01,
        MSIE_OP_SHIFT = 2'b10,
        MSIE_OP_IND   = 2'b11
    } msie_op_t;

    typedef enum logic [1:0] {
        MSIE_PMODE_PREINC  = 2'b00,
        MSIE_PMODE_PREDEC  = 2'b01,
        MSIE_PMODE_POSTINC = 2'b10,
        MSIE_PMODE_POSTDEC = 2'b11
    } msie_pmode_t;

    typedef enum logic [1:0] {
        MSIE_S_IDLE  = 2'b00,
        MSIE_S_EXEC  = 2'b01,
        MSIE_S_BUSRD = 2'b10
    } msie_state_t;

endpackage

// file: core/msie_mem.sv
// Data memory with one port and a registered read.
`timescale 1ns/1ns
`default_nettype none
module msie_mem (
    // Clock
    input  wire logic        i_clk,
    // Access port
    input  wire logic        i_en,
    input  wire logic        i_we,
    input  wire logic [11:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    output var  logic [7:0]  o_rdata
);

    logic [7:0] mem [msie_pkg::MSIE_MEM_DEPTH];

    // No reset on the array: contents are undefined until written.
    always_ff @(posedge i_clk) begin
        if (i_en) begin
            if (i_we) begin
                mem[i_addr] <= i_wdata;
            end else begin
                o_rdata <= mem[i_addr];
            end
        end
    end

endmodule
`default_nettype wire

// file: core/msie_core.sv
// Executes the direct move, right shift and indirect load operations.
// How it works
// - The direct move reads file register 0..127 and writes it to W if d is 0, else back.
// - The direct move updates the zero flag, so a move back tests a register for zero.
// - The right shift moves bits 7..1 to 6..0, puts 0 in bit 7 and bit 0 into carry.
// - The right shift result goes to W if d is 0, else to the file register; C and Z update.
// - The indirect load reads through one of two pointers into W and updates the zero flag.
// - Mode 00 pre-increments, 01 pre-decrements, 10 post-increments, 11 post-decrements.
// - The relative form adds a signed offset -32..31 and leaves the pointer unchanged.
// - The pointer stays within 000h..FFFh and wraps at either end.
// - Pointer stepping never changes any status flag.
`timescale 1ns/1ns
`default_nettype none
module msie_core (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output var  logic [31:0] O_PRDATA,
    output var  logic        O_PREADY,
    output var  logic        O_PSLVERR,
    // Core state
    output var  logic [7:0]  O_WREG,
    output var  logic        O_CARRY,
    output var  logic        O_ZERO,
    output var  logic        O_BUSY
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        msie_pkg::msie_state_t state;
        msie_pkg::msie_op_t    op;
        logic                  dest;
        logic                  pidx;
        logic                  rel;
        logic [1:0]            pmode;
        logic [6:0]            faddr;
        logic [5:0]            ofs;
        logic [7:0]            w;
        logic                  c;
        logic                  z;
        logic [11:0]           ptr0;
        logic [11:0]           ptr1;
        logic [11:0]           maddr;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
        logic                  busy;
    } msie_regs_t;

    msie_regs_t s_r;
    msie_regs_t s_nxt;

    logic        mem_en;
    logic        mem_we;
    logic [11:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata;
    logic [7:0]  result;
    logic        acc;
    logic        start;
    logic [11:0] sel_ptr;
    logic [11:0] cur_ptr;

    // ------------------------------------------------------------------
    // Pointer arithmetic
    // ------------------------------------------------------------------
    // Twelve-bit sums wrap by width, which keeps the pointer in range.
    function automatic logic [11:0] msie_eff_addr(input logic [11:0] p, input logic rel,
                                                  input logic [1:0] pm, input logic [5:0] k);
        if (rel) begin
            return p + {{6{k[5]}}, k};
        end
        case (pm)
            msie_pkg::MSIE_PMODE_PREINC: return p + 12'h001;
            msie_pkg::MSIE_PMODE_PREDEC: return p - 12'h001;
            default:                  return p;
        endcase
    endfunction

    function automatic logic [11:0] msie_ptr_next(input logic [11:0] p, input logic rel,
                                                  input logic [1:0] pm);
        if (rel) begin
            return p;
        end
        if (pm[0]) begin
            return p - 12'h001;
        end
        return p + 12'h001;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    assign acc     = I_PSEL && I_PENABLE && !s_r.pready;
    assign sel_ptr = I_PWDATA[msie_pkg::MSIE_CMD_PSEL] ? s_r.ptr1 : s_r.ptr0;
    assign cur_ptr = s_r.pidx ? s_r.ptr1 : s_r.ptr0;

    always_comb begin
        s_nxt     = s_r;
        mem_en    = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = 12'h000;
        mem_wdata = 8'h00;
        result    = 8'h00;
        start     = 1'b0;
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        case (s_r.state)
            msie_pkg::MSIE_S_IDLE: begin
                if (acc) begin
                    s_nxt.pready = 1'b1;
                    s_nxt.prdata = 32'h0000_0000;
                    if (I_PWRITE) begin
                        case (I_PADDR)
                            msie_pkg::MSIE_OFS_CMD: begin
                                s_nxt.op    = msie_pkg::msie_op_t'(I_PWDATA[1:0]);
                                s_nxt.dest  = I_PWDATA[msie_pkg::MSIE_CMD_DEST];
                                s_nxt.pidx  = I_PWDATA[msie_pkg::MSIE_CMD_PSEL];
                                s_nxt.rel   = I_PWDATA[msie_pkg::MSIE_CMD_REL];
                                s_nxt.pmode = I_PWDATA[msie_pkg::MSIE_CMD_PMODE_LSB +: 2];
                                s_nxt.faddr = I_PWDATA[msie_pkg::MSIE_CMD_F_LSB +: 7];
                                s_nxt.ofs   = I_PWDATA[msie_pkg::MSIE_CMD_K_LSB +: 6];
                                if (I_PWDATA[1:0] != 2'b00) begin
                                    start       = 1'b1;
                                    mem_en      = 1'b1;
                                    s_nxt.state = msie_pkg::MSIE_S_EXEC;
                                    if (I_PWDATA[1:0] == 2'b11) begin
                                        mem_addr = msie_eff_addr(sel_ptr,
                                            I_PWDATA[msie_pkg::MSIE_CMD_REL],
                                            I_PWDATA[msie_pkg::MSIE_CMD_PMODE_LSB +: 2],
                                            I_PWDATA[msie_pkg::MSIE_CMD_K_LSB +: 6]);
                                    end else begin
                                        mem_addr = {5'h00, I_PWDATA[msie_pkg::MSIE_CMD_F_LSB +: 7]};
                                    end
                                end
                            end
                            msie_pkg::MSIE_OFS_WREG:   s_nxt.w = I_PWDATA[7:0];
                            msie_pkg::MSIE_OFS_STATUS: begin
                                s_nxt.c = I_PWDATA[msie_pkg::MSIE_ST_CARRY];
                                s_nxt.z = I_PWDATA[msie_pkg::MSIE_ST_ZERO];
                            end
                            msie_pkg::MSIE_OFS_PTR0:  s_nxt.ptr0  = I_PWDATA[11:0];
                            msie_pkg::MSIE_OFS_PTR1:  s_nxt.ptr1  = I_PWDATA[11:0];
                            msie_pkg::MSIE_OFS_MADDR: s_nxt.maddr = I_PWDATA[11:0];
                            msie_pkg::MSIE_OFS_MDATA: begin
                                mem_en    = 1'b1;
                                mem_we    = 1'b1;
                                mem_addr  = s_r.maddr;
                                mem_wdata = I_PWDATA[7:0];
                            end
                            default: s_nxt.pslverr = 1'b1;
                        endcase
                    end else begin
                        case (I_PADDR)
                            msie_pkg::MSIE_OFS_CMD: begin
                                s_nxt.prdata = {10'h000, s_r.ofs, 1'b0, s_r.faddr, 1'b0,
                                                s_r.pmode, s_r.rel, s_r.pidx, s_r.dest, s_r.op};
                            end
                            msie_pkg::MSIE_OFS_WREG:   s_nxt.prdata = {24'h00_0000, s_r.w};
                            msie_pkg::MSIE_OFS_STATUS: s_nxt.prdata = {30'h0000_0000, s_r.z, s_r.c};
                            msie_pkg::MSIE_OFS_PTR0:   s_nxt.prdata = {20'h0_0000, s_r.ptr0};
                            msie_pkg::MSIE_OFS_PTR1:   s_nxt.prdata = {20'h0_0000, s_r.ptr1};
                            msie_pkg::MSIE_OFS_MADDR:  s_nxt.prdata = {20'h0_0000, s_r.maddr};
                            msie_pkg::MSIE_OFS_MDATA: begin
                                // The memory answers one cycle later, so the bus waits.
                                mem_en       = 1'b1;
                                mem_addr     = s_r.maddr;
                                s_nxt.pready = 1'b0;
                                s_nxt.state  = msie_pkg::MSIE_S_BUSRD;
                            end
                            default: s_nxt.pslverr = 1'b1;
                        endcase
                    end
                end
            end
            msie_pkg::MSIE_S_BUSRD: begin
                s_nxt.pready = 1'b1;
                s_nxt.prdata = {24'h00_0000, mem_rdata};
                s_nxt.state  = msie_pkg::MSIE_S_IDLE;
            end
            msie_pkg::MSIE_S_EXEC: begin
                if (s_r.op == msie_pkg::MSIE_OP_SHIFT) begin
                    result  = {1'b0, mem_rdata[7:1]};
                    s_nxt.c = mem_rdata[0];
                end else begin
                    result = mem_rdata;
                end
                s_nxt.z = (result == 8'h00);
                if (s_r.op != msie_pkg::MSIE_OP_IND && s_r.dest) begin
                    mem_en    = 1'b1;
                    mem_we    = 1'b1;
                    mem_addr  = {5'h00, s_r.faddr};
                    mem_wdata = result;
                end else begin
                    s_nxt.w = result;
                end
                // Only the pointer moves here; carry is left alone.
                if (s_r.op == msie_pkg::MSIE_OP_IND && !s_r.pidx) begin
                    s_nxt.ptr0 = msie_ptr_next(cur_ptr, s_r.rel, s_r.pmode);
                end
                if (s_r.op == msie_pkg::MSIE_OP_IND && s_r.pidx) begin
                    s_nxt.ptr1 = msie_ptr_next(cur_ptr, s_r.rel, s_r.pmode);
                end
                s_nxt.state = msie_pkg::MSIE_S_IDLE;
            end
            default: s_nxt.state = msie_pkg::MSIE_S_IDLE;
        endcase
        s_nxt.busy = (s_nxt.state == msie_pkg::MSIE_S_EXEC);
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    msie_mem u_mem (
        .i_clk   (I_CLK),
        .i_en    (mem_en),
        .i_we    (mem_we),
        .i_addr  (mem_addr),
        .i_wdata (mem_wdata),
        .o_rdata (mem_rdata)
    );

    assign O_PRDATA  = s_r.prdata;
    assign O_PREADY  = s_r.pready;
    assign O_PSLVERR = s_r.pslverr;
    assign O_WREG    = s_r.w;
    assign O_CARRY   = s_r.c;
    assign O_ZERO    = s_r.z;
    assign O_BUSY    = s_r.busy;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    logic ex;
    assign ex = (s_r.state == msie_pkg::MSIE_S_EXEC);

    a_move_to_w: assert property (
        ex && s_r.op == msie_pkg::MSIE_OP_MOVE && !s_r.dest |=> O_WREG == $past(mem_rdata))
        else $error("direct move did not load W");
    a_move_back: assert property (
        ex && s_r.op == msie_pkg::MSIE_OP_MOVE && s_r.dest
        |-> mem_we && mem_addr == {5'h00, s_r.faddr} && mem_wdata == mem_rdata)
        else $error("direct move did not write back");
    a_move_zero: assert property (
        ex && s_r.op == msie_pkg::MSIE_OP_MOVE |=> O_ZERO == ($past(mem_rdata) == 8'h00))
        else $error("direct move zero flag wrong");
    a_zero_any: assert property (
        ex |=> O_ZERO == ($past(result) == 8'h00))
        else $error("zero flag does not follow result");
    a_shift_data: assert property (
        ex && s_r.op == msie_pkg::MSIE_OP_SHIFT
        |-> result == {1'b0, mem_rdata[7:1]} ##1 O_CARRY == $past(mem_rdata[0]))
        else $error("shift result or carry wrong");
    a_shift_dest: assert property (
        ex && s_r.op == msie_pkg::MSIE_OP_SHIFT |-> mem_we == s_r.dest)
        else $error("shift destination wrong");
    a_ind_load: assert property (
        ex && s_r.op == msie_pkg::MSIE_OP_IND |-> !mem_we ##1 O_WREG == $past(mem_rdata))
        else $error("indirect load did not reach W");
    a_preinc_addr: assert property (
        start && I_PWDATA[1:0] == 2'b11 && !I_PWDATA[4] && I_PWDATA[6:5] == 2'b00
        |-> mem_addr == sel_ptr + 12'h001)
        else $error("pre-increment address wrong");
    a_rel_keep: assert property (
        start && I_PWDATA[1:0] == 2'b11 && I_PWDATA[4] && !I_PWDATA[3]
        |-> ##2 s_r.ptr0 == $past(s_r.ptr0, 2))
        else $error("relative access moved the pointer");
    a_ptr_wrap: assert property (
        start && I_PWDATA[1:0] == 2'b11 && I_PWDATA[6:3] == 4'b1000 && s_r.ptr0 == 12'hFFF
        |-> ##2 s_r.ptr0 == 12'h000)
        else $error("pointer did not wrap to zero");
    a_ptr_wrap_dn: assert property (
        start && I_PWDATA[1:0] == 2'b11 && I_PWDATA[6:3] == 4'b1100 && s_r.ptr0 == 12'h000
        |-> ##2 s_r.ptr0 == 12'hFFF)
        else $error("pointer did not wrap to the top");
    a_move_carry: assert property (
        ex && s_r.op == msie_pkg::MSIE_OP_MOVE |=> O_CARRY == $past(O_CARRY))
        else $error("direct move changed carry");
    a_ind_carry: assert property (
        ex && s_r.op == msie_pkg::MSIE_OP_IND |=> O_CARRY == $past(O_CARRY))
        else $error("pointer step changed carry");

    c_move_back: cover property (ex && s_r.op == msie_pkg::MSIE_OP_MOVE && s_r.dest);
    c_shift_w:   cover property (ex && s_r.op == msie_pkg::MSIE_OP_SHIFT && !s_r.dest);
    c_ind_rel:   cover property (ex && s_r.op == msie_pkg::MSIE_OP_IND && s_r.rel);
    c_ptr_wrap:  cover property (start && I_PWDATA[1:0] == 2'b11 && s_r.ptr0 == 12'hFFF);

endmodule
`default_nettype wire

// file: dv/test_move_shift_indirect_exec.sv
// Self-checking random testbench for the move, shift and indirect load unit.
`timescale 1ns/1ns
`default_nettype none
module test_move_shift_indirect_exec;
    logic        clk        = 1'b0;
    logic        rst        = 1'b1;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = 8'h00;
    logic [31:0] pwdata     = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  wreg;
    logic        carry;
    logic        zero;
    logic        busy;
    logic [31:0] seed       = 32'h0000_0060;
    logic [31:0] rd;
    logic        err;
    logic        bz;
    int          num_errors = 0;
    int          n_compared = 0;

    msie_core dut (
        .I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_WREG(wreg), .O_CARRY(carry), .O_ZERO(zero), .O_BUSY(busy)
    );

    always #4 clk = ~clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [11:0] ea_f(logic [11:0] p, logic [1:0] m, logic r, logic [5:0] k);
        if (r) return p + {{6{k[5]}}, k};
        if (m == 2'b00) return p + 12'h001;
        if (m == 2'b01) return p - 12'h001;
        return p;
    endfunction

    // Relative form never moves the pointer; otherwise mode bit 0 picks the direction.
    function automatic logic [11:0] np_f(logic [11:0] p, logic [1:0] m, logic r);
        if (r) return p;
        return m[0] ? p - 12'h001 : p + 12'h001;
    endfunction

    task automatic results();
        $display("Checks made %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // The request is held until the edge at which pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1, "pready timeout");
        rd  = prdata;
        err = pslverr;
        bz  = busy;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdr(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic setmem(input logic [11:0] a, input logic [7:0] v);
        wr(msie_pkg::MSIE_OFS_MADDR, {20'h0_0000, a});
        wr(msie_pkg::MSIE_OFS_MDATA, {24'h00_0000, v});
    endtask

    task automatic getmem(input logic [11:0] a);
        wr(msie_pkg::MSIE_OFS_MADDR, {20'h0_0000, a});
        rdr(msie_pkg::MSIE_OFS_MDATA);
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [7:0]  v;
        logic [7:0]  w0;
        logic [7:0]  res;
        logic [6:0]  f;
        logic [11:0] p;
        logic [11:0] a;
        logic [5:0]  k;
        logic [1:0]  op;
        logic [1:0]  m;
        logic        d;
        logic        rel;
        logic        cs;
        logic        ce;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdr(msie_pkg::MSIE_OFS_WREG);
        chk(rd, 32'h0000_0000, "W after reset");
        rdr(msie_pkg::MSIE_OFS_STATUS);
        chk(rd, 32'h0000_0000, "status after reset");
        rdr(msie_pkg::MSIE_OFS_PTR1);
        chk(rd, 32'h0000_0000, "pointer after reset");
        rdr(8'h1C);
        chk({rd[30:0], err}, 32'h0000_0001, "unmapped read");
        wr(msie_pkg::MSIE_OFS_CMD, 32'h003F_7F7C);
        chk({31'h0, bz}, 32'h0000_0000, "busy on idle command");
        rdr(msie_pkg::MSIE_OFS_CMD);
        chk(rd, 32'h003F_7F7C, "command readback");
        rdr(msie_pkg::MSIE_OFS_WREG);
        chk(rd, 32'h0000_0000, "W after idle command");
        $display("Test reset and map done");
        for (int i = 0; i < 24; i++) begin
            r   = rnd();
            op  = i[1] ? 2'b10 : 2'b01;
            d   = i[0];
            f   = (i < 2) ? {7{i[0]}} : r[6:0];
            v   = (i == 2) ? 8'h00 : (i == 6) ? 8'h01 : (i == 7) ? 8'h80 : r[15:8];
            w0  = r[23:16];
            cs  = r[24];
            res = op[1] ? {1'b0, v[7:1]} : v;
            ce  = op[1] ? v[0] : cs;
            wr(msie_pkg::MSIE_OFS_WREG, {24'h00_0000, w0});
            wr(msie_pkg::MSIE_OFS_STATUS, {30'h0, res != 8'h00, cs});
            setmem({5'h00, f}, v);
            wr(msie_pkg::MSIE_OFS_CMD, {17'h0_0000, f, 5'h00, d, op});
            chk({31'h0, bz}, 32'h0000_0001, "busy");
            rdr(msie_pkg::MSIE_OFS_WREG);
            chk(rd, {24'h00_0000, d ? w0 : res}, "W result");
            chk({24'h00_0000, wreg}, {24'h00_0000, d ? w0 : res}, "W port");
            getmem({5'h00, f});
            chk(rd, {24'h00_0000, d ? res : v}, "file result");
            rdr(msie_pkg::MSIE_OFS_STATUS);
            chk(rd, {30'h0, res == 8'h00, ce}, "flags");
            chk({30'h0, zero, carry}, {30'h0, res == 8'h00, ce}, "flag ports");
        end
        $display("Test move and shift done");
        for (int j = 0; j < 18; j++) begin
            r   = rnd();
            m   = j[2:1];
            rel = (j >= 12);
            p   = (j % 3 == 0) ? 12'h000 : (j % 3 == 1) ? 12'hFFF : r[11:0];
            k   = (j == 12) ? 6'h20 : (j == 13) ? 6'h1F : r[17:12];
            v   = (j == 3) ? 8'h00 : r[25:18];
            cs  = r[26];
            a   = ea_f(p, m, rel, k);
            setmem(a, v);
            wr(j[0] ? msie_pkg::MSIE_OFS_PTR1 : msie_pkg::MSIE_OFS_PTR0, {20'h0_0000, p});
            wr(msie_pkg::MSIE_OFS_STATUS, {30'h0, v != 8'h00, cs});
            wr(msie_pkg::MSIE_OFS_CMD, {10'h000, k, 9'h000, m, rel, j[0], 1'b0, 2'b11});
            rdr(msie_pkg::MSIE_OFS_WREG);
            chk(rd, {24'h00_0000, v}, "indirect W");
            rdr(j[0] ? msie_pkg::MSIE_OFS_PTR1 : msie_pkg::MSIE_OFS_PTR0);
            chk(rd, {20'h0_0000, np_f(p, m, rel)}, "pointer");
            rdr(msie_pkg::MSIE_OFS_STATUS);
            chk(rd, {30'h0, v == 8'h00, cs}, "indirect flags");
        end
        $display("Test indirect load done");
        results();
    end

    initial begin
        #200000;
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end
endmodule
`default_nettype wire
